// [pkg/t3cs_pkg.sv]
// Constants for the timer control and status block: register map, field positions, reset values, dividers.
package t3cs_pkg;
  localparam logic [7:0]  ADDR_CTRL     = 8'h91;
  localparam logic [7:0]  ADDR_RLD_LO   = 8'h92;
  localparam logic [7:0]  ADDR_RLD_HI   = 8'h93;
  localparam logic [7:0]  ADDR_CNT_LO   = 8'h94;
  localparam logic [7:0]  ADDR_CNT_HI   = 8'h95;

  localparam int          BIT_HFLAG     = 7;
  localparam int          BIT_LFLAG     = 6;
  localparam int          BIT_LIRQ_EN   = 5;
  localparam int          BIT_CAP_EN    = 4;
  localparam int          BIT_SPLIT     = 3;
  localparam int          BIT_RUN       = 2;
  localparam int          BIT_UNUSED    = 1;
  localparam int          BIT_ALT_CLK   = 0;

  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] RLD_RESET     = 16'h0000;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [7:0]  BYTE_MAX      = 8'hff;
  localparam logic [15:0] WORD_MAX      = 16'hffff;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  localparam int          SYS_DIV       = 12;
  localparam int          EXT_DIV       = 8;
endpackage

// [hdl/t3cs_sys_div.sv]
// Prescaler that emits one system clock tick every DIV enabled cycles.
`timescale 1ns/1ps
module t3cs_sys_div #(
  parameter int DIV = t3cs_pkg::SYS_DIV
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  output logic      tick
);
  import t3cs_pkg::*;

  localparam int CW = $clog2(DIV);

  generate
    if (DIV < 2) begin : g_bad_div
      $error("t3cs_sys_div: DIV must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } t3cs_div_t;

  t3cs_div_t st;
  t3cs_div_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == CW'(DIV - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// [hdl/t3cs_ext_div.sv]
// Brings the external oscillator into the system clock domain and divides its rising edges by DIV.
`timescale 1ns/1ps
module t3cs_ext_div #(
  parameter int DIV = t3cs_pkg::EXT_DIV
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic ext_osc,
  output logic      tick
);
  import t3cs_pkg::*;

  localparam int CW = $clog2(DIV);

  generate
    if (DIV < 2) begin : g_bad_div
      $error("t3cs_ext_div: DIV must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          prev;
    logic [CW-1:0] cnt;
    logic          tick;
  } t3cs_ext_t;

  t3cs_ext_t st;
  t3cs_ext_t next_st;

  // Only the second synchroniser stage feeds the edge detector; the oscillator must stay
  // below half the system clock rate or edges are lost.
  always_comb begin
    next_st = st;
    next_st.sync1 = ext_osc;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.tick = 1'b0;
    if (st.sync2 && !st.prev) begin
      if (st.cnt == CW'(DIV - 1)) begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// [hdl/t3cs_timer.sv]
// Timer with sixteen-bit or split eight-bit auto-reload, its control register and its special function registers.
`timescale 1ns/1ps
module t3cs_timer #(
  parameter int SYS_DIVIDE = t3cs_pkg::SYS_DIV,
  parameter int EXT_DIVIDE = t3cs_pkg::EXT_DIV
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       high_byte_clock_select,
  input  wire logic       low_byte_clock_select,
  input  wire logic       timer_irq_enable,
  input  wire logic       ext_osc,
  input  wire logic       lfo_out,
  output logic            timer_irq
);
  import t3cs_pkg::*;

  generate
    if (SYS_DIVIDE < 2 || EXT_DIVIDE < 2) begin : g_bad_divide
      $error("t3cs_timer: both dividers must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        high_byte_overflow_flag;
    logic        low_byte_overflow_flag;
    logic        low_byte_irq_enable;
    logic        lfo_capture_enable;
    logic        split_mode_select;
    logic        timer_run;
    logic        alt_clock_select;
    logic        lfo_prev;
    logic        irq;
    logic [7:0]  rdata;
  } t3cs_state_t;

  t3cs_state_t st;
  t3cs_state_t next_st;

  logic sys_tick;
  logic ext_tick;
  logic alt_tick;
  logic tick_lo;
  logic tick_hi;
  logic lfo_rise;
  logic hset;
  logic lset;
  logic wr_ctrl;

  t3cs_sys_div #(
    .DIV (SYS_DIVIDE)
  ) u_sys_div (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .tick   (sys_tick)
  );

  t3cs_ext_div #(
    .DIV (EXT_DIVIDE)
  ) u_ext_div (
    .clk     (clk),
    .arst_n  (arst_n),
    .ce      (ce),
    .ext_osc (ext_osc),
    .tick    (ext_tick)
  );

  assign alt_tick = st.alt_clock_select ? ext_tick : sys_tick;
  assign tick_lo  = low_byte_clock_select | alt_tick;
  assign tick_hi  = high_byte_clock_select | alt_tick;
  assign lfo_rise = lfo_out & ~st.lfo_prev;
  assign wr_ctrl  = sfr_wr && (sfr_addr == ADDR_CTRL);

  always_comb begin
    next_st = st;
    hset = 1'b0;
    lset = 1'b0;
    next_st.lfo_prev = lfo_out;

    // The whole word follows the low byte clock select in sixteen-bit mode.
    if (!st.split_mode_select) begin
      if (st.timer_run && tick_lo) begin
        if (st.cnt == WORD_MAX) begin
          next_st.cnt = st.rld;
          hset = 1'b1;
          lset = 1'b1;
        end else begin
          lset = (st.cnt[7:0] == BYTE_MAX);
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
    end else begin
      if (tick_lo) begin
        if (st.cnt[7:0] == BYTE_MAX) begin
          next_st.cnt[7:0] = st.rld[7:0];
          lset = 1'b1;
        end else begin
          next_st.cnt[7:0] = st.cnt[7:0] + 8'h01;
        end
      end
      if (st.timer_run && tick_hi) begin
        if (st.cnt[15:8] == BYTE_MAX) begin
          next_st.cnt[15:8] = st.rld[15:8];
          hset = 1'b1;
        end else begin
          next_st.cnt[15:8] = st.cnt[15:8] + 8'h01;
        end
      end
    end

    // A software write to a counter byte overrides the increment in the same cycle.
    if (sfr_wr && sfr_addr == ADDR_CNT_LO) begin
      next_st.cnt[7:0] = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == ADDR_CNT_HI) begin
      next_st.cnt[15:8] = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == ADDR_RLD_LO) begin
      next_st.rld[7:0] = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == ADDR_RLD_HI) begin
      next_st.rld[15:8] = sfr_wdata;
    end
    // Capture wins over a reload write so the measured count is never lost.
    if (st.lfo_capture_enable && lfo_rise) begin
      next_st.rld = st.cnt;
    end

    if (wr_ctrl) begin
      next_st.high_byte_overflow_flag = sfr_wdata[BIT_HFLAG];
      next_st.low_byte_overflow_flag  = sfr_wdata[BIT_LFLAG];
      next_st.low_byte_irq_enable     = sfr_wdata[BIT_LIRQ_EN];
      next_st.lfo_capture_enable      = sfr_wdata[BIT_CAP_EN];
      next_st.split_mode_select       = sfr_wdata[BIT_SPLIT];
      next_st.timer_run               = sfr_wdata[BIT_RUN];
      next_st.alt_clock_select        = sfr_wdata[BIT_ALT_CLK];
    end
    if (hset) begin
      next_st.high_byte_overflow_flag = 1'b1;
    end
    if (lset) begin
      next_st.low_byte_overflow_flag = 1'b1;
    end

    // The request follows the high flag, and the low flag when its enable is set, one cycle later; a capture adds a one-cycle pulse.
    next_st.irq = timer_irq_enable &&
                  (st.high_byte_overflow_flag ||
                   (st.low_byte_overflow_flag && st.low_byte_irq_enable) ||
                   (st.lfo_capture_enable && lfo_rise));

    unique case (sfr_addr)
      ADDR_CTRL: begin
        next_st.rdata = {st.high_byte_overflow_flag, st.low_byte_overflow_flag, st.low_byte_irq_enable,
                         st.lfo_capture_enable, st.split_mode_select, st.timer_run,
                         1'b0, st.alt_clock_select};
      end
      ADDR_RLD_LO: begin
        next_st.rdata = st.rld[7:0];
      end
      ADDR_RLD_HI: begin
        next_st.rdata = st.rld[15:8];
      end
      ADDR_CNT_LO: begin
        next_st.rdata = st.cnt[7:0];
      end
      ADDR_CNT_HI: begin
        next_st.rdata = st.cnt[15:8];
      end
      default: begin
        next_st.rdata = UNMAPPED_READ;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{cnt: CNT_RESET, rld: RLD_RESET, rdata: UNMAPPED_READ, default: 1'b0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign sfr_rdata = st.rdata;
  assign timer_irq = st.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_HFLAG_SPLIT: assert property (
    ce && st.split_mode_select && st.timer_run && tick_hi && st.cnt[15:8] == BYTE_MAX
    && !(sfr_wr && sfr_addr == ADDR_CNT_HI)
    |=> st.high_byte_overflow_flag && st.cnt[15:8] == $past(st.rld[15:8]))
    else $error("High byte wrap did not set flag and reload.");

  AST_HFLAG_WORD: assert property (
    ce && !st.split_mode_select && st.timer_run && tick_lo && st.cnt == WORD_MAX && !sfr_wr
    && !(st.lfo_capture_enable && lfo_rise)
    |=> st.high_byte_overflow_flag && st.low_byte_overflow_flag && st.cnt == st.rld)
    else $error("Word wrap did not set flags and reload.");

  AST_IRQ_HIGH: assert property (
    ce && timer_irq_enable && st.high_byte_overflow_flag |=> timer_irq)
    else $error("Set high flag did not raise the interrupt.");

  AST_HFLAG_HOLD: assert property (
    ce && st.high_byte_overflow_flag && !(wr_ctrl && !sfr_wdata[BIT_HFLAG])
    |=> st.high_byte_overflow_flag)
    else $error("High flag cleared without a software write of zero.");

  AST_LFLAG_SET: assert property (
    ce && tick_lo && st.cnt[7:0] == BYTE_MAX && (st.split_mode_select || st.timer_run)
    |=> st.low_byte_overflow_flag)
    else $error("Low byte wrap did not set the low flag.");

  AST_LIRQ_GATE: assert property (
    ce && !st.high_byte_overflow_flag && !(st.lfo_capture_enable && lfo_rise)
    && !(timer_irq_enable && st.low_byte_irq_enable && st.low_byte_overflow_flag)
    |=> !timer_irq)
    else $error("Interrupt raised without an enabled source.");

  AST_CAPTURE: assert property (
    ce && st.lfo_capture_enable && lfo_out && !st.lfo_prev |=> st.rld == $past(st.cnt))
    else $error("Oscillator edge did not capture the count.");

  AST_RUN_GATE: assert property (
    ce && !st.timer_run && !st.split_mode_select && !sfr_wr |=> st.cnt == $past(st.cnt))
    else $error("Stopped timer changed its count.");

  AST_SPLIT_LOW_RUNS: assert property (
    ce && st.split_mode_select && tick_lo && st.cnt[7:0] != BYTE_MAX && !sfr_wr
    |=> st.cnt[7:0] == $past(st.cnt[7:0]) + 8'h01)
    else $error("Low byte did not count in split mode.");

  AST_BIT1_ZERO: assert property (
    ce && sfr_addr == ADDR_CTRL |=> !sfr_rdata[BIT_UNUSED])
    else $error("Unused control bit read as one.");

  AST_SYSTEM_CLOCK_SEL: assert property (
    ce && st.split_mode_select && low_byte_clock_select && st.cnt[7:0] < 8'hfe && !sfr_wr
    ##1 ce && low_byte_clock_select && !sfr_wr |=> st.cnt[7:0] == $past(st.cnt[7:0], 2) + 8'h02)
    else $error("Low byte did not count every cycle on the system clock.");

  AST_SET_WINS: assert property (
    ce && wr_ctrl && !sfr_wdata[BIT_HFLAG] && hset |=> st.high_byte_overflow_flag)
    else $error("Software clear beat a hardware set.");

  // The counter checks below leave out cycles in which a register write may override the counter.
  AST_IRQ_OFF: assert property (
    ce && !timer_irq_enable |=> !timer_irq)
    else $error("Interrupt raised while timer interrupts are disabled.");

  AST_CAPTURE_IRQ: assert property (
    ce && timer_irq_enable && st.lfo_capture_enable && lfo_rise |=> timer_irq)
    else $error("Oscillator capture did not request an interrupt.");

  AST_CTRL_WRITE: assert property (
    ce && wr_ctrl |=> st.split_mode_select == $past(sfr_wdata[BIT_SPLIT])
    && st.timer_run == $past(sfr_wdata[BIT_RUN]) && st.alt_clock_select == $past(sfr_wdata[BIT_ALT_CLK]))
    else $error("Control write did not land in the mode bits.");

  AST_LFLAG_HOLD: assert property (
    ce && st.low_byte_overflow_flag && !(wr_ctrl && !sfr_wdata[BIT_LFLAG])
    |=> st.low_byte_overflow_flag)
    else $error("Low flag cleared without a software write of zero.");

  AST_HIGH_HALT: assert property (
    ce && st.split_mode_select && !st.timer_run && !(sfr_wr && sfr_addr == ADDR_CNT_HI)
    |=> st.cnt[15:8] == $past(st.cnt[15:8]))
    else $error("Stopped high byte changed in split mode.");

  AST_WORD_ALT: assert property (
    ce && !st.split_mode_select && !low_byte_clock_select && !alt_tick && !sfr_wr
    |=> st.cnt == $past(st.cnt))
    else $error("Word counted without a tick of the alternate timebase.");

  AST_SPLIT_ALT: assert property (
    ce && st.split_mode_select && !high_byte_clock_select && !alt_tick && !(sfr_wr && sfr_addr == ADDR_CNT_HI)
    |=> st.cnt[15:8] == $past(st.cnt[15:8]))
    else $error("High byte counted without a tick of the alternate timebase.");

  AST_LOW_RELOAD: assert property (
    ce && st.split_mode_select && tick_lo && st.cnt[7:0] == BYTE_MAX && !(sfr_wr && sfr_addr == ADDR_CNT_LO)
    |=> st.cnt[7:0] == $past(st.rld[7:0]))
    else $error("Low byte did not reload after its wrap.");

  COV_WORD_WRAP: cover property (ce && !st.split_mode_select && hset);
  COV_SPLIT_BOTH: cover property (ce && st.split_mode_select && hset && lset);
  COV_CAPTURE: cover property (ce && st.lfo_capture_enable && lfo_rise && timer_irq_enable);
  COV_EXT_TICK: cover property (ce && st.alt_clock_select && ext_tick && tick_lo);
  COV_SET_WINS: cover property (ce && wr_ctrl && !sfr_wdata[BIT_HFLAG] && hset);
endmodule

// [testbench/t3cs_timer_tb.sv]
// Self-checking testbench for the timer control and status block.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end
module t3cs_timer_tb;
  import t3cs_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       hi_sel = 1'b1;
  logic       lo_sel = 1'b1;
  logic       irq_en = 1'b1;
  logic       ext_osc = 1'b0;
  logic       lfo_out = 1'b0;
  logic       timer_irq;
  logic [7:0] v;
  int         err_total = 0;
  int         n_checks = 0;

  always #2 clk = ~clk;

  t3cs_timer t3cs_timer_i (
    .clk                    (clk),
    .arst_n                 (arst_n),
    .ce                     (ce),
    .sfr_addr               (sfr_addr),
    .sfr_wr                 (sfr_wr),
    .sfr_wdata              (sfr_wdata),
    .sfr_rdata              (sfr_rdata),
    .high_byte_clock_select (hi_sel),
    .low_byte_clock_select  (lo_sel),
    .timer_irq_enable       (irq_en),
    .ext_osc                (ext_osc),
    .lfo_out                (lfo_out),
    .timer_irq              (timer_irq)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address is presented.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask

  task automatic t_reset_map();
    rd(ADDR_CTRL, v);   `CHK("ctrl reset", 8'h00, v)
    rd(ADDR_RLD_LO, v); `CHK("reload low reset", 8'h00, v)
    rd(ADDR_RLD_HI, v); `CHK("reload high reset", 8'h00, v)
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, v);   `CHK("unused bit", 8'h00, v)
    wr(8'h90, 8'h5a);
    rd(8'h90, v);       `CHK("unmapped read", 8'h00, v)
    $display("test reset_map done");
  endtask

  task automatic t_word_wrap();
    wr(ADDR_RLD_LO, 8'h00);
    wr(ADDR_RLD_HI, 8'h12);
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h05);
    rd(ADDR_CTRL, v);   `CHK("flags on word wrap", 8'hc5, v)
    rd(ADDR_CNT_HI, v); `CHK("reloaded high byte", 8'h12, v)
    `CHK("irq on high flag", 1'b1, timer_irq)
    @(posedge clk);
    irq_en <= 1'b0;
    repeat (2) @(posedge clk);
    irq_en <= 1'b1;
    #1 `CHK("irq gated off", 1'b0, timer_irq)
    repeat (50) @(posedge clk);
    rd(ADDR_CTRL, v);   `CHK("flags held", 8'hc5, v)
    wr(ADDR_CTRL, 8'h05);
    rd(ADDR_CTRL, v);   `CHK("flags cleared", 8'h05, v)
    `CHK("irq dropped", 1'b0, timer_irq)
    repeat (260) @(posedge clk);
    rd(ADDR_CTRL, v);   `CHK("low flag in word mode", 8'h45, v)
    `CHK("low flag masked", 1'b0, timer_irq)
    wr(ADDR_CTRL, 8'h65);
    repeat (2) @(posedge clk);
    #1 `CHK("low flag enabled", 1'b1, timer_irq)
    wr(ADDR_CTRL, 8'h00);
    $display("test word_wrap done");
  endtask

  // Low byte keeps counting with run low, the high byte must hold.
  task automatic t_split();
    wr(ADDR_RLD_LO, 8'ha0);
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CNT_HI, 8'h50);
    wr(ADDR_CTRL, 8'h08);
    repeat (40) @(posedge clk);
    rd(ADDR_CTRL, v);   `CHK("split low flag only", 8'h48, v)
    rd(ADDR_CNT_HI, v); `CHK("high byte halted", 8'h50, v)
    rd(ADDR_CNT_LO, v); `CHK("low reload range", 1'b1, (v >= 8'ha0 && v < 8'hd0))
    `CHK("split irq masked", 1'b0, timer_irq)
    wr(ADDR_RLD_HI, 8'h30);
    wr(ADDR_CNT_HI, 8'hfe);
    // The second write writes zero to the high flag in the very cycle that the high byte wraps.
    wr(ADDR_CTRL, 8'h0c);
    wr(ADDR_CTRL, 8'h0c);
    rd(ADDR_CTRL, v);   `CHK("split high flag", 1'b1, v[BIT_HFLAG])
    `CHK("split high irq", 1'b1, timer_irq)
    rd(ADDR_CNT_HI, v); `CHK("split high reload", 8'h33, v)
    wr(ADDR_CTRL, 8'h00);
    $display("test split done");
  endtask

  task automatic t_timebase();
    hi_sel <= 1'b0;
    lo_sel <= 1'b0;
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    repeat (120) @(posedge clk);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO, v); `CHK("system over twelve", 1'b1, (v >= 8'h09 && v <= 8'h0b))
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h0d);
    for (int i = 0; i < 80; i++) begin
      repeat (5) @(posedge clk);
      ext_osc <= ~ext_osc;
    end
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CNT_LO, v); `CHK("external over eight", 1'b1, (v >= 8'h03 && v <= 8'h05))
    rd(ADDR_CNT_HI, v); `CHK("external high byte", 1'b1, (v >= 8'h03 && v <= 8'h05))
    hi_sel <= 1'b1;
    lo_sel <= 1'b1;
    $display("test timebase done");
  endtask

  task automatic t_capture();
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h77);
    wr(ADDR_CTRL, 8'h14);
    repeat (5) @(posedge clk);
    lfo_out <= 1'b1;
    @(posedge clk);
    #1 `CHK("capture irq pulse", 1'b1, timer_irq)
    @(posedge clk);
    #1 `CHK("capture irq ends", 1'b0, timer_irq)
    @(posedge clk);
    lfo_out <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_RLD_HI, v); `CHK("captured high byte", 8'h77, v)
    rd(ADDR_RLD_LO, v); `CHK("captured low range", 1'b1, (v >= 8'h04 && v <= 8'h08))
    $display("test capture done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_map();
    t_word_wrap();
    t_split();
    t_timebase();
    t_capture();
    wrap_up();
  end

  // The tests need about a thousand cycles, so this span of 25000 cycles leaves ample margin.
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
